//--- logic/lcd_driver.sv
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
// ****************************************
// Segment display driver control with APB registers
// ****************************************
module lcd_driver
    import lcd_pkg::*;
#(
    parameter int SEGMENTS = 32
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [DATA_W-1:0]   pwdata,
    input  wire logic [3:0]          pstrb,
    output logic [DATA_W-1:0]        prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                slow_rc_clk,
    input  wire logic                slow_xtal_clk,
    input  wire logic                low_speed_source_select,
    output logic [NUM_COMMONS-1:0]   com_level_hi,
    output logic [NUM_COMMONS-1:0]   com_level_lo,
    output logic [NUM_COMMONS-1:0]   com_oe,
    output logic [SEGMENTS-1:0]      seg_level_hi,
    output logic [SEGMENTS-1:0]      seg_level_lo,
    output logic [SEGMENTS-1:0]      seg_oe,
    output logic                     pump_clk_out,
    output analog_ctrl_t             analog_ctrl
);

    if (SEGMENTS != 24 && SEGMENTS != 32) begin : g_bad_segments
        $error("SEGMENTS must be 24 or 32");
    end

    localparam logic [11:0] MEM_LAST = 12'((SEGMENTS - 1) * 4);

    logic [3:0]              mem_reg [SEGMENTS];
    main_ctrl_t              main_reg;
    ladder_ctrl_t            ladder_reg;
    logic [2:0]              pump_div_reg;
    logic [1:0]              com_idx_reg;
    logic                    frame_phase_reg;
    logic [3:0]              qc_cnt_reg;
    logic                    src_tick;
    logic                    scan_tick;
    logic                    pump_tick;
    logic                    wr_en;
    logic                    rd_en;
    logic                    mem_hit;
    logic [DATA_W-1:0]       rd_next;
    logic                    err_next;
    logic [SEGMENTS-1:0]     seg_on;
    logic                    seg_idx_ok;

    lcd_clock_gen u_clk (
        .pclk                    (pclk),
        .presetn                 (presetn),
        .slow_rc_clk             (slow_rc_clk),
        .slow_xtal_clk           (slow_xtal_clk),
        .low_speed_source_select (low_speed_source_select),
        .pump_clock_divider      (pump_div_reg),
        .src_tick                (src_tick),
        .scan_tick               (scan_tick),
        .pump_tick               (pump_tick)
    );

    // ****************************************
    // APB slave
    // ****************************************
    function automatic logic is_mem(input logic [11:0] a);
        return (a[1:0] == 2'h0) && (a <= MEM_LAST);
    endfunction

    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & penable & ~pwrite;
    // RULE1: display memory window
    assign mem_hit = is_mem(paddr);

    // RULE5: upper nibble never stored
    always_ff @(posedge pclk) begin
        if (wr_en && mem_hit && pstrb[0]) begin
            mem_reg[paddr[6:2]] <= pwdata[3:0] & MEM_MASK[3:0];
        end
    end

    // RULE12: waveform bit, RULE13 bias kind, RULE20 enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_reg     <= main_ctrl_t'(MAIN_CTRL_RST);
            ladder_reg   <= ladder_ctrl_t'(LADDER_CTRL_RST);
            pump_div_reg <= PUMP_CTRL_RST[2:0];
        end else if (wr_en && pstrb[0]) begin
            case (paddr)
                MAIN_CTRL_ADDR:   main_reg   <= main_ctrl_t'(pwdata[7:0]);
                // RULE21: bit 4 not stored
                LADDER_CTRL_ADDR: ladder_reg <= ladder_ctrl_t'(pwdata[7:0] & LADDER_CTRL_MASK);
                PUMP_CTRL_ADDR:   pump_div_reg <= pwdata[2:0] & PUMP_CTRL_MASK[2:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        rd_next  = '0;
        err_next = 1'b0;
        if (mem_hit) begin
            // RULE5: reads zero above nibble
            rd_next[3:0] = mem_reg[paddr[6:2]];
        end else begin
            case (paddr)
                MAIN_CTRL_ADDR:   rd_next[7:0] = main_reg;
                LADDER_CTRL_ADDR: rd_next[7:0] = ladder_reg;
                PUMP_CTRL_ADDR:   rd_next[2:0] = pump_div_reg;
                STATUS_ADDR:      rd_next[2:0] = {frame_phase_reg, com_idx_reg};
                default:          err_next = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & err_next;
            if (psel && !penable && !pwrite) begin
                prdata <= rd_next;
            end
        end
    end

    // ****************************************
    // Scan sequencer
    // ****************************************
    // RULE6: quarter duty, RULE22 disable resets scan
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            com_idx_reg     <= 2'h0;
            frame_phase_reg <= 1'b0;
        end else if (!main_reg.display_enable) begin
            com_idx_reg     <= 2'h0;
            frame_phase_reg <= 1'b0;
        end else if (scan_tick) begin
            // RULE24: commons in turn
            com_idx_reg <= com_idx_reg + 2'h1;
            if (com_idx_reg == 2'(NUM_COMMONS - 1)) begin
                frame_phase_reg <= ~frame_phase_reg;
            end
        end
    end

    // RULE18: low-resistance interval counter, RULE17 restarts each phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qc_cnt_reg <= 4'h0;
        end else if (scan_tick || !main_reg.display_enable) begin
            qc_cnt_reg <= {1'b0, ladder_reg.quick_charge_duration} + 4'h1;
        end else if (src_tick && qc_cnt_reg != 4'h0) begin
            qc_cnt_reg <= qc_cnt_reg - 4'h1;
        end
    end

    // RULE3 RULE4: segment data from live memory
    generate
        for (genvar s = 0; s < SEGMENTS; s++) begin : g_seg
            assign seg_on[s] = mem_reg[s][com_idx_reg];
        end
    endgenerate

    // ****************************************
    // Output drive
    // ****************************************
    // RULE7: levels on 2-bit code {hi,lo}: top=11, 2/3=10, 1/3=01, gnd=00
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // RULE23: float in reset
            com_oe       <= '0;
            seg_oe       <= '0;
            com_level_hi <= '0;
            com_level_lo <= '0;
            seg_level_hi <= '0;
            seg_level_lo <= '0;
        end else if (!main_reg.display_enable) begin
            // RULE22: driven low when off
            com_oe       <= '1;
            seg_oe       <= '1;
            com_level_hi <= '0;
            com_level_lo <= '0;
            seg_level_hi <= '0;
            seg_level_lo <= '0;
        end else begin
            com_oe <= '1;
            seg_oe <= '1;
            for (int c = 0; c < NUM_COMMONS; c++) begin
                // Selected common at top or ground, others at 1/3 or 2/3
                com_level_hi[c] <= (c == int'(com_idx_reg)) ? ~frame_phase_reg
                                                            : frame_phase_reg;
                com_level_lo[c] <= (c == int'(com_idx_reg)) ? ~frame_phase_reg
                                                            : ~frame_phase_reg;
            end
            for (int s = 0; s < SEGMENTS; s++) begin
                // On pixel: opposite extreme; off pixel: intermediate level
                seg_level_hi[s] <= seg_on[s] ? frame_phase_reg : ~frame_phase_reg;
                seg_level_lo[s] <= seg_on[s] ? frame_phase_reg : frame_phase_reg;
            end
        end
    end

    // ****************************************
    // Analog controls
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_ctrl  <= '0;
            analog_ctrl.outputs_float <= 1'b1;
            pump_clk_out <= 1'b0;
        end else begin
            analog_ctrl.drive_on      <= main_reg.display_enable;
            analog_ctrl.outputs_float <= 1'b0;
            // RULE13: pump on with pump bias
            analog_ctrl.pump_enable   <= main_reg.display_enable & main_reg.bias_kind_select;
            // RULE15: pump supply source
            analog_ctrl.pump_power_source <= main_reg.pump_power_source;
            // RULE19: ladder top numerator over 16
            analog_ctrl.ladder_numerator <= ladder_reg.ladder_top_level_select[3]
                ? 5'(LADDER_DENOM)
                : 5'(BIAS_TOP_CODE) + {2'b0, ladder_reg.ladder_top_level_select[2:0]};
            analog_ctrl.wave_type_b <= main_reg.wave_type_b;
            // RULE16 RULE17: fixed or quick-charge resistor choice
            case (main_reg.bias_resistor_select)
                3'h0:    analog_ctrl.resistor <= RES_HIGH;
                3'h1:    analog_ctrl.resistor <= RES_MEDIUM;
                3'h2:    analog_ctrl.resistor <= RES_LOW;
                3'h3:    analog_ctrl.resistor <= (qc_cnt_reg != 4'h0) ? RES_LOW : RES_HIGH;
                default: analog_ctrl.resistor <= (qc_cnt_reg != 4'h0) ? RES_LOW : RES_MEDIUM;
            endcase
            // RULE11: pump clock out when pump runs
            pump_clk_out <= pump_tick & main_reg.bias_kind_select & main_reg.display_enable;
        end
    end

endmodule // lcd_driver

//--- logic/lcd_pkg.sv
// Operation
// RULE1: Display memory words 0x00..0x17 or 0x1F act on display data.
// RULE2: Software loads pointer high byte 04H before indirect display access.
// RULE3: Driver reads display memory continuously; writes show without further action.
// RULE4: Memory bit one drives pixel on, zero drives it off.
// RULE5: Bits 4 to 7 of each display byte read zero, store nothing.
// RULE6: Fixed one quarter duty, four commons per frame.
// RULE7: One third bias with four levels: ground, top, two thirds, third.
// RULE8: Scan clock is display source clock divided by eight.
// RULE9: Source clock from slow internal RC or slow crystal, by select bit.
// RULE10: Pump base divides slow clock by 8,4,2,1 per divider code.
// RULE11: Pump output clock is base halved per code, 250Hz up to 16kHz.
// RULE12: Main control bit 7 selects waveform type A or B.
// RULE13: Bit 6 selects ladder or pump bias; pump bias enables pump.
// RULE14: With ladder bias software keeps pump power source at 00.
// RULE15: Bits 5..4 select pump supply: pin, reference, core mid, core top.
// RULE16: Bits 3..1 select high, medium, low resistance or quick charge.
// RULE17: Quick charge uses low resistance at phase start, then higher one.
// RULE18: Quick-charge interval is code plus one source clock periods.
// RULE19: Ladder top level is (8+code)/16 of supply, full for 1xxx.
// RULE20: Display enable bit 0 switches driver off or on in all modes.
// RULE21: Unimplemented control bits read zero.
// RULE22: Clearing enable resets the function and drives outputs low.
// RULE23: During device reset outputs float regardless of enable.
// RULE24: Commons scanned in turn, segments driven from that common's bits.
package lcd_pkg;

    localparam int          DATA_W           = 32;
    localparam int          ADDR_W           = 12;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] MEM_BASE         = 12'h000;
    localparam logic [11:0] MAIN_CTRL_ADDR   = 12'h100;
    localparam logic [11:0] LADDER_CTRL_ADDR = 12'h104;
    localparam logic [11:0] PUMP_CTRL_ADDR   = 12'h108;
    localparam logic [11:0] STATUS_ADDR      = 12'h10C;
    localparam logic [7:0]  MAIN_CTRL_RST    = 8'h00;
    localparam logic [7:0]  LADDER_CTRL_RST  = 8'h00;
    localparam logic [7:0]  PUMP_CTRL_RST    = 8'h00;
    localparam logic [7:0]  LADDER_CTRL_MASK = 8'hEF;
    localparam logic [7:0]  PUMP_CTRL_MASK   = 8'h07;
    localparam logic [7:0]  MEM_MASK         = 8'h0F;
    localparam int          NUM_COMMONS      = 4;
    // Source clock ticks per common phase (one scan tick)
    localparam int          SCAN_DIV         = 8;
    localparam int          BIAS_TOP_CODE    = 8;
    localparam int          LADDER_DENOM     = 16;

    // ****************************************
    // Field carriers
    // ****************************************
    typedef struct packed {
        logic       wave_type_b;
        logic       bias_kind_select;
        logic [1:0] pump_power_source;
        logic [2:0] bias_resistor_select;
        logic       display_enable;
    } main_ctrl_t;

    typedef struct packed {
        logic [2:0] quick_charge_duration;
        logic       unused;
        logic [3:0] ladder_top_level_select;
    } ladder_ctrl_t;

    typedef enum logic [1:0] {
        RES_HIGH,
        RES_MEDIUM,
        RES_LOW
    } bias_res_t;

    typedef enum logic [1:0] {
        LEVEL_GROUND,
        LEVEL_THIRD,
        LEVEL_TWO_THIRDS,
        LEVEL_TOP
    } drive_level_t;

    typedef struct packed {
        logic         drive_on;
        logic         outputs_float;
        logic         pump_enable;
        logic [1:0]   pump_power_source;
        logic [4:0]   ladder_numerator;
        bias_res_t    resistor;
        logic         wave_type_b;
    } analog_ctrl_t;

endpackage

//--- logic/lcd_clock_gen.sv
`timescale 1ns/100ps
// Derives source and scan clock enables and the toggling pump clock level from a slow oscillator pin
module lcd_clock_gen
    import lcd_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       slow_rc_clk,
    input  wire logic       slow_xtal_clk,
    input  wire logic       low_speed_source_select,
    input  wire logic [2:0] pump_clock_divider,
    output logic            src_tick,
    output logic            scan_tick,
    output logic            pump_tick
);

    logic [2:0] sync_reg;
    logic [2:0] scan_cnt_reg;
    logic [3:0] pump_cnt_reg;
    logic [3:0] pump_cnt_next;
    logic       pump_out_reg;
    logic       pump_base;
    logic       src_pin;
    logic [3:0] pump_half;

    // ****************************************
    // Source select and synchroniser
    // ****************************************
    // RULE9: slow source select
    assign src_pin = low_speed_source_select ? slow_xtal_clk : slow_rc_clk;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_reg <= 3'h0;
        end else begin
            sync_reg <= {sync_reg[1:0], src_pin};
        end
    end

    // Rising edge counts once stages two and three agree
    logic src_prev_reg;
    logic src_edge;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_prev_reg <= 1'b0;
        end else if (sync_reg[1] == sync_reg[2]) begin
            src_prev_reg <= sync_reg[2];
        end
    end
    assign src_edge = (sync_reg[1] == sync_reg[2]) & sync_reg[2] & ~src_prev_reg;
    assign src_tick = src_edge;

    // ****************************************
    // Dividers
    // ****************************************
    // RULE8: scan is source / 8
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_cnt_reg <= 3'h0;
        end else if (src_edge) begin
            scan_cnt_reg <= scan_cnt_reg + 3'h1;
        end
    end
    assign scan_tick = src_edge & (scan_cnt_reg == 3'(SCAN_DIV - 1));

    // RULE10: pump base divide by 8,4,2,1
    always_comb begin
        case (pump_clock_divider)
            3'h4:    pump_base = src_edge & (scan_cnt_reg[1:0] == 2'h3);
            3'h5:    pump_base = src_edge & scan_cnt_reg[0];
            3'h6,
            3'h7:    pump_base = src_edge;
            default: pump_base = scan_tick;
        endcase
    end

    // RULE11: base halved, or /16 ../4 at lowest codes
    always_comb begin
        case (pump_clock_divider)
            3'h0:    pump_half = 4'h7;
            3'h1:    pump_half = 4'h3;
            3'h2:    pump_half = 4'h1;
            default: pump_half = 4'h0;
        endcase
    end

    always_comb begin
        pump_cnt_next = pump_cnt_reg + 4'h1;
        if (pump_cnt_reg >= pump_half) begin
            pump_cnt_next = 4'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pump_cnt_reg <= 4'h0;
            pump_out_reg <= 1'b0;
        end else if (pump_base) begin
            pump_cnt_reg <= pump_cnt_next;
            if (pump_cnt_reg >= pump_half) begin
                pump_out_reg <= ~pump_out_reg;
            end
        end
    end
    assign pump_tick = pump_out_reg;

endmodule // lcd_clock_gen

//--- verification/lcd_driver_chk.sv
`timescale 1ns/100ps
module lcd_driver_chk
    import lcd_pkg::*;
#(
    parameter int SEGMENTS = 32
) (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [ADDR_W-1:0]      paddr,
    input wire logic [DATA_W-1:0]      pwdata,
    input wire logic [3:0]             pstrb,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic [NUM_COMMONS-1:0] com_level_hi,
    input wire logic [NUM_COMMONS-1:0] com_level_lo,
    input wire logic [NUM_COMMONS-1:0] com_oe,
    input wire logic [SEGMENTS-1:0]    seg_level_hi,
    input wire logic [SEGMENTS-1:0]    seg_level_lo,
    input wire logic [SEGMENTS-1:0]    seg_oe,
    input wire analog_ctrl_t           analog_ctrl
);
    logic [7:0] sh;
    logic [7:0] age;
    logic       unmapped;
    logic       main_wr;
    assign unmapped = (paddr < 12'h100 && paddr[11:2] >= SEGMENTS) || paddr > 12'h10C;
    assign main_wr = psel && penable && pready && pwrite && pstrb[0]
                     && paddr == MAIN_CTRL_ADDR;
    // Shadow of the main control register, seen from the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh <= MAIN_CTRL_RST;
        end else if (main_wr) begin
            sh <= pwdata[7:0];
        end
    end
    // Saturates above one common phase so scanning has begun
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age <= 8'hFF;
        end else if (main_wr) begin
            age <= 8'h00;
        end else if (age != 8'hFF) begin
            age <= age + 8'h01;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        psel && penable && pready;
    endsequence
    AST_PREADY_ONE: assert property (s_setup |=> s_answer)
        else $error("no answer after setup");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready held too long");
    AST_UNMAPPED_ERR: assert property (s_setup ##0 unmapped |=> pready && pslverr)
        else $error("unmapped access not refused");
    AST_OE_DRIVEN: assert property ($past(presetn) |-> &com_oe && &seg_oe)
        else $error("outputs not driven out of reset");
    AST_DISABLED_LOW: assert property (!sh[0] && age >= 8'h04 |->
        com_level_hi == '0 && com_level_lo == '0 && seg_level_hi == '0 && seg_level_lo == '0)
        else $error("outputs not low while disabled");
    AST_ONE_SELECTED: assert property (sh[0] && age == 8'hFF |->
        $onehot(~(com_level_hi ^ com_level_lo)))
        else $error("not exactly one common selected");
    AST_MAIN_FIELDS: assert property (age >= 8'h04 |->
        analog_ctrl.wave_type_b == sh[7] && analog_ctrl.pump_power_source == sh[5:4]
        && analog_ctrl.drive_on == sh[0])
        else $error("main control fields not applied");
    AST_PUMP_ON: assert property (sh[0] && age >= 8'h04 |->
        analog_ctrl.pump_enable == sh[6])
        else $error("pump enable differs from bias kind");
    AST_RES_FIXED: assert property (sh[0] && age >= 8'h04 && sh[3:1] < 3'd3 |->
        analog_ctrl.resistor == bias_res_t'(sh[2:1]))
        else $error("fixed resistor choice not applied");
endmodule // lcd_driver_chk

bind lcd_driver lcd_driver_chk #(.SEGMENTS(SEGMENTS)) lcd_driver_chk_i (.*);

//--- verification/lcd_panel_model.sv
`timescale 1ns/100ps
module lcd_panel_model
    import lcd_pkg::*;
#(
    parameter int SEGMENTS = 32
) (
    input  wire logic                   pclk,
    input  wire logic [NUM_COMMONS-1:0] com_level_hi,
    input  wire logic [NUM_COMMONS-1:0] com_level_lo,
    input  wire logic [NUM_COMMONS-1:0] com_oe,
    input  wire logic [SEGMENTS-1:0]    seg_level_hi,
    input  wire logic [SEGMENTS-1:0]    seg_level_lo,
    output logic [NUM_COMMONS-1:0]      pix [SEGMENTS],
    output int                          phase_len
);
    int         sel;
    int         last_sel = -1;
    int         cnt = 0;
    int         hits;
    logic [1:0] cl;
    logic [1:0] sl;
    always @(posedge pclk) begin
        hits = 0;
        cnt++;
        for (int c = 0; c < NUM_COMMONS; c++) begin
            if (com_level_hi[c] == com_level_lo[c]) begin
                hits++;
                sel = c;
            end
        end
        if (&com_oe && hits == 1) begin
            if (sel != last_sel) begin
                phase_len = cnt;
                cnt = 0;
                last_sel = sel;
            end
            cl = {com_level_hi[sel], com_level_lo[sel]};
            // Full swing is on, one third is off, any other gap is illegal
            for (int s = 0; s < SEGMENTS; s++) begin
                sl = {seg_level_hi[s], seg_level_lo[s]};
                pix[s][sel] = (sl == ~cl) ? 1'b1 : (sl == (cl ^ 2'b01)) ? 1'b0 : 1'bx;
            end
        end
    end
endmodule // lcd_panel_model

//--- verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import lcd_pkg::*;
    localparam int SEG = 32;
    localparam int SP  = 16;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pump_clk_out;
    logic slow_rc_clk, slow_xtal_clk, low_speed_source_select, er;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [3:0] pstrb, com_level_hi, com_level_lo, com_oe;
    logic [SEG-1:0] seg_level_hi, seg_level_lo, seg_oe;
    analog_ctrl_t analog_ctrl;
    logic [3:0] pix [SEG];
    logic [3:0] pat [SEG];
    int phase_len, n_mismatch, checks, cnt;
    int pdiv [8] = '{128, 64, 32, 16, 8, 4, 2, 2};
    longint t0;

    lcd_driver #(.SEGMENTS(SEG)) lcd_driver_i (.*);
    lcd_panel_model #(.SEGMENTS(SEG)) lcd_panel_model_i (.*);

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Slow clocks kept fast so a frame fits the run
    initial begin
        slow_rc_clk = 1'b0;
        #7;
        forever #(SP * 20) slow_rc_clk = ~slow_rc_clk;
    end
    initial begin
        slow_xtal_clk = 1'b0;
        #9;
        forever #400 slow_xtal_clk = ~slow_xtal_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0000_0000);
        check(rd, exp);
    endtask
    task automatic pix_chk(input int wait_cyc);
        repeat (wait_cyc) @(posedge pclk);
        for (int s = 0; s < SEG; s++) check(32'(pix[s]), 32'(pat[s]));
    endtask
    task automatic pump_period(input int exp);
        repeat (2) @(posedge pump_clk_out);
        t0 = $time;
        @(posedge pump_clk_out);
        check(32'(($time - t0) / 40), 32'(exp));
    endtask
    task automatic quick(input logic [7:0] m, input int q, input bias_res_t after);
        wr(MAIN_CTRL_ADDR, {24'h0, m});
        wr(LADDER_CTRL_ADDR, 32'(q << 5));
        cnt = 0;
        @(negedge pclk);
        while (analog_ctrl.resistor != RES_LOW) @(negedge pclk);
        while (analog_ctrl.resistor != RES_LOW || cnt == 0) begin
            cnt = (analog_ctrl.resistor != RES_LOW) ? 1 : 0;
            @(negedge pclk);
        end
        cnt = 0;
        while (analog_ctrl.resistor == RES_LOW) begin
            cnt++;
            @(negedge pclk);
        end
        check(32'(cnt), 32'((q + 1) * SP));
        check(32'(analog_ctrl.resistor), 32'(after));
        check(32'(analog_ctrl.ladder_numerator), 32'(BIAS_TOP_CODE));
    endtask
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge pclk);
        n_mismatch++;
        conclude();
    end

    initial begin
        {presetn, psel, penable, pwrite, low_speed_source_select} = 5'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hF;
        repeat (2) @(posedge pclk);
        check(32'(|{com_oe, seg_oe}), 32'h0000_0000);
        presetn <= 1'b1;
        rdchk(MAIN_CTRL_ADDR, 32'h0000_0000);
        rdchk(LADDER_CTRL_ADDR, 32'h0000_0000);
        rdchk(PUMP_CTRL_ADDR, 32'h0000_0000);
        wr(LADDER_CTRL_ADDR, 32'h0000_00FF);
        rdchk(LADDER_CTRL_ADDR, 32'h0000_00EF);
        check(32'(analog_ctrl.ladder_numerator), 32'(LADDER_DENOM));
        wr(PUMP_CTRL_ADDR, 32'h0000_00FF);
        rdchk(PUMP_CTRL_ADDR, 32'h0000_0007);
        wr(MAIN_CTRL_ADDR, 32'h0000_00FE);
        rdchk(MAIN_CTRL_ADDR, 32'h0000_00FE);
        wr(12'h014, 32'h0000_00FF);
        rdchk(12'h014, 32'h0000_000F);
        xfer(12'(4 * SEG), 1'b0, 32'h0000_0000);
        check(32'(er), 32'h0000_0001);
        check(32'(|{com_level_hi, seg_level_hi, com_level_lo, seg_level_lo}), 32'h0);
        $display("registers done");
        for (int s = 0; s < SEG; s++) begin
            pat[s] = 4'(s * 5 + 3);
            wr(12'(4 * s), 32'(pat[s]));
        end
        rdchk(12'(4 * (SEG - 1)), 32'(pat[SEG - 1]));
        wr(MAIN_CTRL_ADDR, 32'h0000_0001);
        pix_chk(2600);
        check(32'(phase_len), 32'(SCAN_DIV * SP));
        pat[7] = ~pat[7];
        wr(12'h01C, 32'(pat[7]));
        pix_chk(2600);
        wr(MAIN_CTRL_ADDR, 32'h0000_0083);
        pix_chk(5200);
        wr(MAIN_CTRL_ADDR, 32'h0000_0000);
        repeat (8) @(posedge pclk);
        check(32'(|{com_level_hi, seg_level_hi, seg_level_lo, com_level_lo}), 32'h0);
        $display("display done");
        wr(MAIN_CTRL_ADDR, 32'h0000_0045);
        for (int k = 0; k < 8; k++) begin
            wr(PUMP_CTRL_ADDR, 32'(k));
            pump_period(SP * pdiv[k]);
        end
        low_speed_source_select <= 1'b1;
        pump_period(40);
        low_speed_source_select <= 1'b0;
        $display("pump done");
        quick(8'h07, 0, RES_HIGH);
        quick(8'h09, 3, RES_MEDIUM);
        $display("quick charge done");
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        check(32'(|{com_oe, seg_oe}), 32'h0000_0000);
        presetn <= 1'b1;
        rdchk(MAIN_CTRL_ADDR, 32'h0000_0000);
        $display("reset done");
        conclude();
    end
endmodule // tb_top
